// [cam_model.sv]
// Camera model: packs samples back to back, oldest in the low bits
module cam_model (
	// Clock
	input  wire logic        ref_clk,
	// Link side
	input  wire logic        in_ready,
	output logic             in_valid,
	output logic      [31:0] in_data,
	output logic             in_sof
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle link at time zero
	initial begin
		in_valid = 1'b0;
		in_sof   = 1'b0;
		in_data  = 32'h0;
	end

	// One frame; a word is held until taken, bounded wait
	task automatic send(input logic [15:0] s[$], input int d);
		logic [63:0] acc;
		int          nb, g;
		acc = 64'h0;
		nb = 0;
		in_sof <= 1'b1;
		foreach (s[i]) begin
			acc = acc | (64'(s[i]) << nb);
			nb = nb + d;
			// Last partial word still goes out, no padding
			while (nb >= 32 || (i == s.size() - 1 && nb > 0)) begin
				in_valid <= 1'b1;
				in_data <= acc[31:0];
				g = 0;
				do @(posedge ref_clk);
				while (in_ready !== 1'b1 && ++g < 2000);
				in_sof <= 1'b0;
				acc = acc >> 32;
				nb = nb - 32;
			end
		end
		// Released data line shows the inverse
		in_valid <= 1'b0;
		in_data <= ~acc[31:0];
	endtask : send
endmodule : cam_model

// [line_mem.sv]
// One-line sample store used by colour interpolation, registered read
module line_mem #(
	parameter int DEPTH = 4096,
	parameter int W     = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock
	input  wire logic          ref_clk,
	// Write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [W-1:0]  wr_data,
	// Read side
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [W-1:0]  rd_data
);
	logic [W-1:0] mem [DEPTH];   // Sample array, no reset needed

	// Read data holds while rd_en is low, so a stalled reader keeps it
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : line_mem

// [pix_stream_if.sv]
// Valid/ready word carrier between the stage and its output buffer
interface pix_stream_if #(
	parameter int W = 8
);
	logic         valid;   // Word offered
	logic         ready;   // Word taken when both high
	logic [W-1:0] data;    // Word payload

	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface : pix_stream_if

// [pixel_unpack_format_stage.sv]
// Pixel unpack, colour conversion and format reporting stage
//
// Overview of operation
// - 10/12/14 bit pixels unpacked into 16-bit containers
// - 8 and 16 bit pixels pass unchanged
// - Two alignments, low and high, selectable
// - Low alignment keeps value, upper bits zero
// - High alignment shifts up, low bits zero
// - High alignment reports 10/12/14 bit input as a 16 bit format, except when interpolated
// - Output format follows input and four settings
// - Report width, height, depth, pattern or null
// - Interpolation turns mosaic input into RGB
// - Exchange swaps red and blue, width kept
// - Flip reverses rows, reports swapped pattern
module pixel_unpack_format_stage
	import unpack_pkg::*;
#(
	parameter int MAX_WIDTH = 4096
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Packed link stream, header beside the sof word
	input  wire logic        in_valid,
	input  wire logic [31:0] in_data,
	input  wire logic        in_sof,
	input  wire logic [15:0] hdr_width,
	input  wire logic [15:0] hdr_height,
	input  wire logic [4:0]  hdr_depth,
	input  wire logic [1:0]  hdr_class,
	input  wire logic [2:0]  hdr_pattern,
	output logic             in_ready,
	// Unpacked pixels toward host memory
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic      [47:0] out_data,
	output logic      [15:0] out_row,
	output logic      [15:0] out_col,
	output logic             out_sof,
	output logic             out_last
);
	localparam int AW    = $clog2(MAX_WIDTH);
	localparam int BUF_W = PIX_W + 16 + 16 + 2;

	// Frame phase
	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_RUN  = 1'b1
	} phase_type;

	// Whole state of the stage
	typedef struct packed {
		phase_type          phase;     // Inside a frame
		logic               in_ready;  // Room for one more link word
		logic [ACC_W-1:0]   acc;       // Bit accumulator, oldest bits low
		logic [CNT_W-1:0]   cnt;       // Valid bits in acc
		logic [3:0]         ctrl;      // Software settings
		logic [3:0]         run_ctrl;  // Settings frozen for this frame
		logic [15:0]        width;     // Frame width in pixels
		logic [15:0]        height;    // Frame height in rows
		logic [4:0]         depth;     // Bits per sample
		colour_class_type   cls;       // Colour class
		mosaic_type         pattern;   // Mosaic pattern of the input
		logic [15:0]        col;       // Next pixel column
		logic [15:0]        row;       // Next pixel row
		logic [1:0]         comp;      // Component index for RGB input
		logic [31:0]        gather;    // First two RGB components
		logic [15:0]        frames;    // Completed frames
		logic [31:0]        rdata;     // Read data, one cycle after strobe
		logic               a_valid;   // Pixel stage holds a pixel
		logic [PIX_W-1:0]   a_data;    // Containers of the held pixel
		logic [BYTE_W-1:0]  a_byte;    // Top 8 bits of the held sample
		logic [15:0]        a_row;     // Input row of the held pixel
		logic [15:0]        a_col;     // Column of the held pixel
		logic [15:0]        a_orow;    // Row as written to memory
		logic               a_sof;     // First pixel of frame
		logic               a_last;    // Last pixel of frame
		logic [BYTE_W-1:0]  left;      // Sample to the left
		logic [BYTE_W-1:0]  upleft;    // Sample up and to the left
	} stage_state_type;

	stage_state_type s_ff, nxt_s;

	// Combinational helpers
	logic              take; // A sample leaves the accumulator
	logic              pix_done; // That sample completes a pixel
	logic              a_adv; // Held pixel enters the buffer
	logic              accept; // A link word is taken
	logic              last_pix; // Completing pixel ends the frame
	logic              mem_rd; // Fetch sample from the row above
	logic [CONT_W-1:0] raw; // Sample at its own width
	logic [CONT_W-1:0] cont; // Sample in its container
	logic [BYTE_W-1:0] byt; // Sample reduced to 8 bits
	logic [ACC_W-1:0]  acc_s; // Accumulator after the take
	logic [CNT_W-1:0]  cnt_s; // Count after the take
	logic [BYTE_W-1:0] mem_up; // Sample above, from the line store
	logic [BYTE_W-1:0] left_v; // Edge-corrected left sample
	logic [BYTE_W-1:0] up_v; // Edge-corrected upper sample
	logic [BYTE_W-1:0] ul_v; // Edge-corrected corner sample
	logic [23:0]       rgb; // Interpolated {b,g,r}
	logic [PIX_W-1:0]  pix_out; // Pixel offered to the buffer

	pix_stream_if #(.W(BUF_W)) buf_in ();
	pix_stream_if #(.W(BUF_W)) buf_out ();

	// Mask of the low depth bits
	function automatic logic [CONT_W-1:0] depth_mask(input logic [4:0] d);
		logic [CONT_W:0] m;
		m = (17'h1 << d) - 17'h1;
		return m[CONT_W-1:0];
	endfunction : depth_mask

	// True for the widths that get unpacked
	function automatic logic is_packed(input logic [4:0] d);
		return (d == DEPTH10) || (d == DEPTH12) || (d == DEPTH14);
	endfunction : is_packed

	// 2x2 window interpolation: cells cur, left, up, upleft in v
	function automatic logic [23:0] demosaic(input mosaic_type p,
		input logic rb, input logic cb, input logic [31:0] v);
		logic [8:0] gs;
		logic [7:0] rr;
		logic [7:0] bb;
		logic       r;
		logic       c;
		logic       g_diag;
		logic       red_top;
		gs      = 9'h000;
		rr      = 8'h00;
		bb      = 8'h00;
		g_diag  = (p == PAT_GR) || (p == PAT_GB);
		red_top = (p == PAT_RG) || (p == PAT_GR);
		for (int k = 0; k < 4; k++) begin
			r = rb ^ k[1];
			c = cb ^ k[0];
			if ((r ^ c) != g_diag) begin
				gs = gs + {1'b0, v[k*8 +: 8]};
			end else if (r != red_top) begin
				rr = v[k*8 +: 8];
			end else begin
				bb = v[k*8 +: 8];
			end
		end
		return {bb, gs[8:1], rr};
	endfunction : demosaic

	// Reported output format
	function automatic logic [31:0] out_fmt(input logic [3:0] ctl,
		input colour_class_type cl, input logic [4:0] d,
		input mosaic_type p);
		colour_class_type oc;
		logic [4:0]       od;
		mosaic_type       op;
		oc = cl;
		od = d;
		op = p;
		if (ctl[ALIGN_HIGH_BIT] && is_packed(d)) begin
			od = DEPTH16;
		end
		if (cl == CLS_BAYER && ctl[INTERP_BIT]) begin
			oc = ctl[EXCHANGE_BIT] ? CLS_BGR : CLS_RGB;
			od = DEPTH8;
			op = PAT_NULL;
		end else if (cl == CLS_RGB || cl == CLS_BGR) begin
			if (ctl[EXCHANGE_BIT]) begin
				oc = (cl == CLS_RGB) ? CLS_BGR : CLS_RGB;
			end
		end else if (cl == CLS_BAYER && ctl[FLIP_BIT]) begin
			// Row reversal moves the top-left cell to the other row
			case (p)
				PAT_RG:  op = PAT_GB;
				PAT_GB:  op = PAT_RG;
				PAT_GR:  op = PAT_BG;
				PAT_BG:  op = PAT_GR;
				default: op = p;
			endcase
		end
		return {13'h0, op, 6'h0, oc, 3'h0, od};
	endfunction : out_fmt

	// Line store for the row above
	line_mem #(
		.DEPTH (MAX_WIDTH),
		.W     (BYTE_W)
	) u_line (
		.ref_clk (ref_clk),
		.wr_en   (a_adv),
		.wr_addr (s_ff.a_col[AW-1:0]),
		.wr_data (s_ff.a_byte),
		.rd_en   (mem_rd),
		.rd_addr (s_ff.col[AW-1:0]),
		.rd_data (mem_up)
	);

	// Two-entry output buffer; a stalled receiver backs up to the link
	skid_buffer #(
		.W (BUF_W)
	) u_buf (
		.ref_clk (ref_clk),
		.rst     (rst),
		.up      (buf_in),
		.down    (buf_out)
	);

	// Pixel offered to the buffer
	always_comb begin
		left_v  = (s_ff.a_col == 16'h0000) ? s_ff.a_byte : s_ff.left;
		up_v    = (s_ff.a_row == 16'h0000) ? s_ff.a_byte : mem_up;
		ul_v    = (s_ff.a_row == 16'h0000) ? left_v :
			((s_ff.a_col == 16'h0000) ? up_v : s_ff.upleft);
		rgb     = demosaic(s_ff.pattern, s_ff.a_row[0], s_ff.a_col[0],
			{ul_v, up_v, left_v, s_ff.a_byte});
		pix_out = s_ff.a_data;
		if (s_ff.cls == CLS_BAYER && s_ff.run_ctrl[INTERP_BIT]) begin
			if (s_ff.run_ctrl[EXCHANGE_BIT]) begin
				pix_out = {8'h00, rgb[7:0], 8'h00, rgb[15:8],
					8'h00, rgb[23:16]};
			end else begin
				pix_out = {8'h00, rgb[23:16], 8'h00, rgb[15:8],
					8'h00, rgb[7:0]};
			end
		end else if (s_ff.cls[1] && s_ff.run_ctrl[EXCHANGE_BIT]) begin
			pix_out = {s_ff.a_data[15:0], s_ff.a_data[31:16],
				s_ff.a_data[47:32]};
		end
	end

	assign buf_in.valid  = s_ff.a_valid;
	assign buf_in.data   = {s_ff.a_sof, s_ff.a_last, s_ff.a_orow,
		s_ff.a_col, pix_out};
	assign buf_out.ready = out_ready;

	// Next state of the whole stage
	always_comb begin
		nxt_s    = s_ff;
		mem_rd   = 1'b0;
		last_pix = 1'b0;
		// Register writes steer the stage
		if (reg_wr && reg_addr == CTRL_OFS) begin
			nxt_s.ctrl = reg_wdata[3:0];
		end
		// Read data stand for one cycle only; unmapped reads give zero
		nxt_s.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				CTRL_OFS:    nxt_s.rdata = {28'h0, s_ff.ctrl};
				WIDTH_OFS:   nxt_s.rdata = {16'h0, s_ff.width};
				HEIGHT_OFS:  nxt_s.rdata = {16'h0, s_ff.height};
				IN_FMT_OFS:  nxt_s.rdata = {13'h0, s_ff.pattern, 6'h0,
					s_ff.cls, 3'h0, s_ff.depth};
				OUT_FMT_OFS: nxt_s.rdata = out_fmt(s_ff.ctrl, s_ff.cls,
					s_ff.depth, s_ff.pattern);
				STATUS_OFS:  nxt_s.rdata = {15'h0, s_ff.phase == PH_RUN,
					s_ff.frames};
				default:     nxt_s.rdata = 32'h0000_0000;
			endcase
		end
		// Held pixel leaves; its samples become the next window's left
		a_adv = s_ff.a_valid && buf_in.ready;
		if (a_adv) begin
			nxt_s.a_valid = 1'b0;
			nxt_s.left    = s_ff.a_byte;
			nxt_s.upleft  = mem_up;
		end
		// One sample per cycle, only when the pixel stage is free
		take  = (s_ff.phase == PH_RUN) && (s_ff.cnt >= {2'b00, s_ff.depth})
			&& (!s_ff.a_valid || a_adv);
		raw   = s_ff.acc[CONT_W-1:0] & depth_mask(s_ff.depth);
		// 8 and 16 bit samples keep their width untouched
		cont  = raw;
		if (s_ff.run_ctrl[ALIGN_HIGH_BIT] && is_packed(s_ff.depth)) begin
			cont = raw << (DEPTH16 - s_ff.depth);
		end
		byt   = 8'(raw >> (s_ff.depth - DEPTH8));
		acc_s = take ? (s_ff.acc >> s_ff.depth) : s_ff.acc;
		cnt_s = take ? (s_ff.cnt - {2'b00, s_ff.depth}) : s_ff.cnt;
		nxt_s.acc = acc_s;
		nxt_s.cnt = cnt_s;
		pix_done = take && !(s_ff.cls[1] && s_ff.comp != 2'h2);
		if (take && !pix_done) begin
			// Park the first two RGB components
			if (s_ff.comp == 2'h0) begin
				nxt_s.gather[15:0] = cont;
			end else begin
				nxt_s.gather[31:16] = cont;
			end
			nxt_s.comp = s_ff.comp + 2'h1;
		end
		if (pix_done) begin
			last_pix = (s_ff.col == s_ff.width - 16'h1) &&
				(s_ff.row == s_ff.height - 16'h1);
			mem_rd        = 1'b1;
			nxt_s.comp    = 2'h0;
			nxt_s.a_valid = 1'b1;
			nxt_s.a_data  = s_ff.cls[1] ? {cont, s_ff.gather}
				: {32'h0000_0000, cont};
			nxt_s.a_byte  = byt;
			nxt_s.a_row   = s_ff.row;
			nxt_s.a_col   = s_ff.col;
			nxt_s.a_sof   = (s_ff.col == 16'h0) && (s_ff.row == 16'h0);
			nxt_s.a_last  = last_pix;
			// With flip set, host writes the row to the mirrored position
			nxt_s.a_orow  = s_ff.run_ctrl[FLIP_BIT]
				? (s_ff.height - 16'h1 - s_ff.row) : s_ff.row;
			if (s_ff.col == s_ff.width - 16'h1) begin
				nxt_s.col = 16'h0000;
				nxt_s.row = s_ff.row + 16'h1;
			end else begin
				nxt_s.col = s_ff.col + 16'h1;
			end
			if (last_pix) begin
				// Trailing pad bits of the frame are dropped
				nxt_s.phase  = PH_IDLE;
				nxt_s.frames = s_ff.frames + 16'h1;
			end
		end
		// A frame start always wins and restarts the unpacker
		accept = s_ff.in_ready && in_valid;
		if (accept && in_sof) begin
			nxt_s.phase    = PH_RUN;
			nxt_s.acc      = {32'h0000_0000, in_data};
			nxt_s.cnt      = WORD_BITS;
			nxt_s.col      = 16'h0000;
			nxt_s.row      = 16'h0000;
			nxt_s.comp     = 2'h0;
			nxt_s.width    = hdr_width;
			nxt_s.height   = hdr_height;
			nxt_s.depth    = hdr_depth;
			nxt_s.cls      = colour_class_type'(hdr_class);
			// Non-mosaic frames always report the null pattern
			nxt_s.pattern  = (hdr_class == CLS_BAYER)
				? mosaic_type'(hdr_pattern) : PAT_NULL;
			nxt_s.run_ctrl = nxt_s.ctrl;
		end else if (accept && s_ff.phase == PH_RUN) begin
			nxt_s.acc = acc_s | ({32'h0000_0000, in_data} << cnt_s);
			nxt_s.cnt = cnt_s + WORD_BITS;
		end
		// Ready only while the next word is certain to fit
		nxt_s.in_ready = (nxt_s.phase == PH_IDLE) ||
			(nxt_s.cnt <= WORD_BITS);
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_ff          <= '0;
			s_ff.in_ready <= 1'b1;
			s_ff.ctrl     <= CTRL_RESET;
			s_ff.run_ctrl <= CTRL_RESET;
			s_ff.depth    <= DEPTH8;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = s_ff.rdata;
	assign in_ready  = s_ff.in_ready;
	assign out_valid = buf_out.valid;
	assign out_data  = buf_out.data[PIX_W-1:0];
	assign out_col   = buf_out.data[PIX_W+15:PIX_W];
	assign out_row   = buf_out.data[PIX_W+31:PIX_W+16];
	assign out_last  = buf_out.data[PIX_W+32];
	assign out_sof   = buf_out.data[PIX_W+33];
endmodule : pixel_unpack_format_stage

// [pixel_unpack_format_stage_sva.sv]
// Port checker for the unpack stage, bound onto its top module
module pixel_unpack_format_stage_sva
	import unpack_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Link side
	input wire logic        in_valid,
	input wire logic        in_sof,
	input wire logic        in_ready,
	input wire logic [4:0]  hdr_depth,
	input wire logic [1:0]  hdr_class,
	input wire logic [2:0]  hdr_pattern,
	// Pixel side
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [47:0] out_data,
	input wire logic [15:0] out_col,
	input wire logic        out_sof
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  ctl_ff;   // Live control copy
	logic [3:0]  fctl_ff;  // Control seen at frame start
	logic [4:0]  dep_ff;   // Frame depth
	logic [1:0]  cls_ff;   // Frame colour class
	logic [2:0]  pat_ff;   // Frame mosaic pattern
	logic [15:0] vmask;    // Bits a low-aligned sample may use
	logic [15:0] lmask;    // Bits high alignment leaves zero
	logic [2:0]  swp;      // Pattern after a row flip
	logic        mono;     // Plain mono frame
	logic        mid;      // Depth that needs unpacking
	logic        fmt_rd;   // Output format read

	assign vmask = 16'((17'h1 << dep_ff) - 17'h1);
	assign lmask = 16'((17'h1 << (5'h10 - dep_ff)) - 17'h1);
	assign swp = (pat_ff == PAT_RG) ? PAT_GB : (pat_ff == PAT_GB) ? PAT_RG :
		(pat_ff == PAT_GR) ? PAT_BG : PAT_GR;
	assign mono = (cls_ff == CLS_MONO);
	assign mid = (dep_ff > DEPTH8) && (dep_ff < DEPTH16);
	assign fmt_rd = reg_rd && (reg_addr == OUT_FMT_OFS);

	// Snoop control writes and headers; datapath uses control at sof
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctl_ff  <= CTRL_RESET;
			fctl_ff <= CTRL_RESET;
			dep_ff  <= DEPTH8;
			cls_ff  <= 2'h0;
			pat_ff  <= 3'h0;
		end else begin
			if (reg_wr && reg_addr == CTRL_OFS) begin
				ctl_ff <= reg_wdata[3:0];
			end
			if (in_valid && in_ready && in_sof) begin
				fctl_ff <= ctl_ff;
				dep_ff  <= hdr_depth;
				cls_ff  <= hdr_class;
				pat_ff  <= hdr_pattern;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("stray read data");
	a_pix_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data) &&
		$stable(out_col)) else $error("stalled pixel changed");
	a_sof_col: assert property (
		out_valid && out_sof |-> out_col == 16'h0)
		else $error("sof not at column zero");
	a_low_value: assert property (
		out_valid && mono && !fctl_ff[ALIGN_HIGH_BIT] |->
		out_data[47:16] == 32'h0 && (out_data[15:0] & ~vmask) == 16'h0)
		else $error("low aligned upper bits set");
	a_high_zero: assert property (
		out_valid && mono && fctl_ff[ALIGN_HIGH_BIT] && mid |->
		(out_data[15:0] & lmask) == 16'h0) else $error("high aligned low bits");
	a_eight_pass: assert property (
		out_valid && mono && dep_ff == DEPTH8 |-> out_data[47:8] == 40'h0)
		else $error("eight bit pixel widened");
	a_high_fmt: assert property (
		fmt_rd && ctl_ff[ALIGN_HIGH_BIT] && mono && mid |=>
		reg_rdata[4:0] == DEPTH16) else $error("high align depth not 16");
	a_in_fmt: assert property (
		reg_rd && reg_addr == IN_FMT_OFS |=>
		reg_rdata[9:0] == {cls_ff, 3'h0, dep_ff} &&
		(cls_ff == CLS_BAYER || reg_rdata[18:16] == 3'h0))
		else $error("input format word wrong");
	a_flip_swap: assert property (
		fmt_rd && cls_ff == CLS_BAYER && ctl_ff[FLIP_BIT] &&
		!ctl_ff[INTERP_BIT] |=> reg_rdata[18:16] == swp)
		else $error("flipped pattern not swapped");
	a_interp_rgb: assert property (
		fmt_rd && cls_ff == CLS_BAYER && ctl_ff[INTERP_BIT] |=>
		reg_rdata[9:0] == {1'b1, $past(ctl_ff[EXCHANGE_BIT]), 3'h0, DEPTH8})
		else $error("interpolated format wrong");
endmodule : pixel_unpack_format_stage_sva

bind pixel_unpack_format_stage pixel_unpack_format_stage_sva u_sva (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .in_valid(in_valid), .in_sof(in_sof),
	.in_ready(in_ready), .hdr_depth(hdr_depth), .hdr_class(hdr_class),
	.hdr_pattern(hdr_pattern), .out_valid(out_valid),
	.out_ready(out_ready), .out_data(out_data), .out_col(out_col),
	.out_sof(out_sof)
);

// [pixel_unpack_format_stage_tb.sv]
// Self-checking bench for the pixel unpack and format stage
module pixel_unpack_format_stage_tb
	import unpack_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0; // 200 MHz clock
	logic        rst = 1'b1; // Async reset
	logic [7:0]  reg_addr = 8'h00; // Register port
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        in_valid, in_sof, in_ready; // Link, from the camera
	logic [31:0] in_data;
	logic [15:0] hdr_width = 16'h1; // Frame header
	logic [15:0] hdr_height = 16'h1;
	logic [4:0]  hdr_depth = 5'h08;
	logic [1:0]  hdr_class = 2'h0;
	logic [2:0]  hdr_pattern = 3'h0;
	logic        out_valid, out_sof, out_last; // Pixel side
	logic        out_ready = 1'b1;
	logic [47:0] out_data;
	logic [15:0] out_row, out_col;
	int          bad_count = 0;
	int          cmp_count = 0;

	always #2.5 ref_clk = ~ref_clk;

	pixel_unpack_format_stage #(.MAX_WIDTH(64)) u_pixel_unpack_format_stage (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_valid(in_valid), .in_data(in_data),
		.in_sof(in_sof), .hdr_width(hdr_width), .hdr_height(hdr_height),
		.hdr_depth(hdr_depth), .hdr_class(hdr_class),
		.hdr_pattern(hdr_pattern), .in_ready(in_ready),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_row(out_row), .out_col(out_col), .out_sof(out_sof),
		.out_last(out_last));

	cam_model u_cam_model (.ref_clk(ref_clk), .in_ready(in_ready),
		.in_valid(in_valid), .in_data(in_data), .in_sof(in_sof));

	// Verdict and end of run
	task automatic close_out();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// Compare one register or position word
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		chk_pix({16'h0, g}, {16'h0, e});
	endtask : chk_reg

	// Compare one pixel word
	task automatic chk_pix(input logic [47:0] g, input logic [47:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_pix

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read strobe, answer taken in the following cycle only
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		chk_reg(reg_rdata, e);
	endtask : rdchk

	// Format word: depth, class, pattern
	function automatic logic [31:0] fw(input int d, input int c, input int p);
		return 32'(d) | (32'(c) << 8) | (32'(p) << 16);
	endfunction : fw

	// Container expected for one sample
	function automatic logic [15:0] cont(input logic [15:0] v, input int d,
		input bit hi);
		return (hi && d > 8 && d < 16) ? 16'(v << (16 - d)) : v;
	endfunction : cont

	// Send a frame while a stalling receiver drains and checks it
	task automatic frame(input int d, input int c, input int p, input int w,
		input int h, input logic [3:0] ctl, input bit dat);
		logic [15:0] s[$];
		logic [15:0] f[3];
		int          n, k, g, r;
		n = w * h;
		wr(CTRL_OFS, {28'h0, ctl});
		for (k = 0; k < n * (c > 1 ? 3 : 1); k++) begin
			s.push_back(16'((k * 419 + 53) & ((1 << d) - 1)));
		end
		hdr_width <= 16'(w);
		hdr_height <= 16'(h);
		hdr_depth <= 5'(d);
		hdr_class <= 2'(c);
		hdr_pattern <= 3'(p);
		k = 0;
		fork
			u_cam_model.send(s, d);
			for (g = 0; g < 5000 && k < n; g++) begin
				out_ready <= (g % 3 != 2);
				@(posedge ref_clk);
				if (out_valid === 1'b1 && out_ready === 1'b1) begin
					r = ctl[FLIP_BIT] ? h - 1 - k / w : k / w;
					chk_reg({out_row, out_col}, {16'(r), 16'(k % w)});
					chk_reg({out_sof, out_last}, {k == 0, k == n - 1});
					for (r = 0; r < 3; r++) begin
						f[r] = cont(s[c > 1 ? 3 * k + r : k], d, ctl[0]);
					end
					if (c < 2 && dat) begin
						chk_pix(out_data, {32'h0, f[0]});
					end else if (dat) begin
						chk_pix(out_data, ctl[EXCHANGE_BIT] ? {f[0], f[1], f[2]} :
							{f[2], f[1], f[0]});
					end
					k++;
				end
			end
		join
		out_ready <= 1'b1;
		if (k < n) begin
			bad_count++;
			close_out();
		end
	endtask : frame

	// Reset value, geometry, read-only and unmapped places
	task automatic t_regs();
		rdchk(CTRL_OFS, 32'h0);
		frame(12, 0, 0, 3, 4, 4'h0, 1);
		rdchk(STATUS_OFS, 32'h1);
		rdchk(WIDTH_OFS, 32'h3);
		rdchk(HEIGHT_OFS, 32'h4);
		wr(WIDTH_OFS, 32'hffff);
		rdchk(WIDTH_OFS, 32'h3);
		rdchk(8'h18, 32'h0);
		wr(CTRL_OFS, 32'hf);
		rdchk(CTRL_OFS, 32'hf);
	endtask : t_regs

	// Every depth in both alignments
	task automatic t_unpack();
		int d, a;
		for (d = 8; d <= 16; d += 2) begin
			for (a = 0; a < 2; a++) begin
				frame(d, 0, 1, 5, 2, 4'(a), 1);
				rdchk(IN_FMT_OFS, fw(d, 0, 0));
				rdchk(OUT_FMT_OFS, fw(a && d > 8 && d < 16 ? 16 : d, 0, 0));
			end
		end
	endtask : t_unpack

	// Flip with all four mosaic patterns
	task automatic t_flip();
		int p;
		for (p = 1; p <= 4; p++) begin
			frame(10, 1, p, 3, 3, 4'h2, 1);
			rdchk(IN_FMT_OFS, fw(10, 1, p));
			rdchk(OUT_FMT_OFS, fw(10, 1, (p + 1) % 4 + 1));
		end
	endtask : t_flip

	// Colour input, exchange and interpolation
	task automatic t_colour();
		int x;
		for (x = 0; x < 2; x++) begin
			frame(8, 2, 0, 2, 2, {x[0], 3'h0}, 1);
			rdchk(OUT_FMT_OFS, fw(8, 2 + x, 0));
			frame(10, 3, 0, 2, 1, {x[0], 3'h1}, 1);
			rdchk(OUT_FMT_OFS, fw(16, 3 - x, 0));
			frame(8, 1, 1, 4, 2, {x[0], 3'h4}, 0);
			rdchk(OUT_FMT_OFS, fw(8, 2 + x, 0));
		end
	endtask : t_colour

	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_unpack();
		t_flip();
		t_colour();
		close_out();
	end
endmodule : pixel_unpack_format_stage_tb

// [skid_buffer.sv]
// Two-entry buffer; output entry is always the head flip-flop
module skid_buffer #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst,
	// Filling and draining sides
	pix_stream_if.dst  up,
	pix_stream_if.src  down
);
	typedef struct packed {
		logic         v0;   // Head entry full
		logic         v1;   // Second entry full
		logic [W-1:0] d0;   // Head word
		logic [W-1:0] d1;   // Second word
	} buf_state_type;

	buf_state_type s_ff, nxt_s;
	logic          pop;
	logic          push;

	// Ready depends only on a flop: refuse once both entries hold words
	assign up.ready   = !s_ff.v1;
	assign down.valid = s_ff.v0;
	assign down.data  = s_ff.d0;

	// Pop shifts the second entry forward
	always_comb begin
		nxt_s = s_ff;
		pop   = s_ff.v0 && down.ready;
		push  = up.valid && !s_ff.v1;
		if (pop) begin
			nxt_s.v0 = s_ff.v1 || push;
			nxt_s.d0 = s_ff.v1 ? s_ff.d1 : up.data;
			nxt_s.v1 = 1'b0;
		end else if (push) begin
			if (!s_ff.v0) begin
				nxt_s.v0 = 1'b1;
				nxt_s.d0 = up.data;
			end else begin
				nxt_s.v1 = 1'b1;
				nxt_s.d1 = up.data;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : skid_buffer

// [unpack_pkg.sv]
// Constants, register map and format types of the unpack stage
package unpack_pkg;

	// Register byte offsets on the plain register port
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] WIDTH_OFS   = 8'h04;
	localparam logic [7:0] HEIGHT_OFS  = 8'h08;
	localparam logic [7:0] IN_FMT_OFS  = 8'h0c;
	localparam logic [7:0] OUT_FMT_OFS = 8'h10;
	localparam logic [7:0] STATUS_OFS  = 8'h14;

	// Control register bit positions and reset value
	localparam int         ALIGN_HIGH_BIT = 0;
	localparam int         FLIP_BIT       = 1;
	localparam int         INTERP_BIT     = 2;
	localparam int         EXCHANGE_BIT   = 3;
	localparam logic [3:0] CTRL_RESET     = 4'h0;

	// Format and status word field positions
	localparam int FMT_DEPTH_POS   = 0;
	localparam int FMT_CLASS_POS   = 8;
	localparam int FMT_PATTERN_POS = 16;
	localparam int STATUS_BUSY_POS = 16;

	// Datapath sizes and thresholds
	localparam int         WORD_W      = 32;
	localparam int         ACC_W       = 64;
	localparam int         CNT_W       = 7;
	localparam int         CONT_W      = 16;
	localparam int         PIX_W       = 48;
	localparam int         BYTE_W      = 8;
	localparam logic [6:0] WORD_BITS   = 7'h20;
	localparam logic [4:0] DEPTH8      = 5'h08;
	localparam logic [4:0] DEPTH10     = 5'h0a;
	localparam logic [4:0] DEPTH12     = 5'h0c;
	localparam logic [4:0] DEPTH14     = 5'h0e;
	localparam logic [4:0] DEPTH16     = 5'h10;

	// Colour class of a frame
	typedef enum logic [1:0] {
		CLS_MONO  = 2'b00,
		CLS_BAYER = 2'b01,
		CLS_RGB   = 2'b10,
		CLS_BGR   = 2'b11
	} colour_class_type;

	// Mosaic pattern code; null for non-mosaic frames
	typedef enum logic [2:0] {
		PAT_NULL = 3'b000,
		PAT_RG   = 3'b001,
		PAT_GR   = 3'b010,
		PAT_GB   = 3'b011,
		PAT_BG   = 3'b100
	} mosaic_type;

endpackage : unpack_pkg
